// ===== tb/cpu_programming_model_test.sv
// Purpose: Self-checking bench for the core register model
// Assumes: Avalon-MM accesses, sync active-high reset, one clock
// Notes: Bus task holds each request until waitrequest is sampled low
`timescale 1ns/1ps
`default_nettype none
module cpu_programming_model_test;
  import cpm_pkg::*;
  logic sys_clk;
  logic rst;
  cpm_avs_req_type req;
  logic [31:0] rdata;
  logic wait_req;
  logic [31:0] fetch_addr;
  logic sup_mode;
  logic icache_en;
  logic fetch_cacheable;
  logic [31:0] vector_base;
  logic [31:0] q;
  int bad_count;
  int n_checks;
  int cycles;
  cpm_core_regs i_dut (.sys_clk(sys_clk), .rst(rst), .avs_req(req),
    .avs_readdata(rdata), .avs_waitrequest(wait_req),
    .fetch_addr(fetch_addr), .sup_mode(sup_mode), .icache_en(icache_en),
    .fetch_cacheable(fetch_cacheable), .vector_base(vector_base));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    req.read <= ~w;
    req.write <= w;
    req.address <= a;
    req.writedata <= d;
    @(posedge sys_clk);
    while (wait_req !== 1'b0) @(posedge sys_clk);
    q = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(OFS_PSW, 32'h0000_2000);
    chk({31'h0, sup_mode}, 32'h1);
    chk({31'h0, icache_en}, 32'h0);
    rd(8'hFC, 32'h0);
  endtask : t_reset
  task automatic t_gen();
    for (int i = 0; i < 16; i++) wr(8'(i * 4), 32'hA500_0000 | i);
    for (int i = 0; i < 16; i++) rd(8'(i * 4), 32'hA500_0000 | i);
  endtask : t_gen
  task automatic t_ctl();
    wr(OFS_XBASE, ALL_ONES);
    rd(OFS_XBASE, 32'hFFF0_0000);
    chk(vector_base, 32'hFFF0_0000);
    wr(OFS_CCTL, 32'h8000_0000);
    chk({31'h0, icache_en}, 32'h1);
    wr(OFS_RA0, 32'h1000_8040);
    wr(OFS_RA1, 32'h3000_8040);
    for (int i = 1; i < 4; i++) begin
      fetch_addr <= {4'(i), 28'h0};
      repeat (3) @(posedge sys_clk);
      chk({31'h0, fetch_cacheable}, 32'(i == 2));
    end
  endtask : t_ctl
  task automatic t_alu();
    wr(OFS_ALU_A, 32'h0);
    wr(OFS_ALU_B, 32'h1);
    wr(OFS_ALU_CTL, 32'h21);
    rd(OFS_ALU_RES, ALL_ONES);
    rd(OFS_FLAGS, 32'h19);
    wr(OFS_ALU_A, 32'h7FFF_FFFF);
    wr(OFS_ALU_CTL, 32'h20);
    rd(OFS_ALU_RES, 32'h8000_0000);
    rd(OFS_FLAGS, 32'h0A);
  endtask : t_alu
  task automatic t_ea();
    wr(8'h20, 32'h1000);
    wr(8'h0C, 32'h4);
    wr(OFS_EA_EXT, 32'h10);
    wr(OFS_EA_CTL, 32'h0002_2306);
    rd(OFS_EA_RES, 32'h1020);
    wr(8'h24, 32'h2000);
    wr(OFS_EA_CTL, 32'h0002_0013);
    rd(OFS_EA_RES, 32'h2000);
    rd(8'h24, 32'h2004);
  endtask : t_ea
  task automatic t_move();
    logic [8:0] tbl [6];
    tbl = '{9'h05B, 9'h155, 9'h1A0, 9'h136, 9'h056, 9'h109};
    foreach (tbl[i]) begin
      wr(OFS_MOVE, {24'h0, tbl[i][7:0]});
      bus(1'b0, OFS_MOVE, 32'h0);
      chk({31'h0, q[0]}, {31'h0, tbl[i][8]});
    end
  endtask : t_move
  task automatic t_priv();
    wr(8'h3C, 32'h100);
    wr(OFS_PSW, 32'h0);
    chk({31'h0, sup_mode}, 32'h0);
    wr(OFS_FLAGS, 32'h05);
    rd(OFS_FLAGS, 32'h05);
    wr(OFS_XBASE, 32'h0010_0000);
    @(posedge sys_clk);
    chk({31'h0, sup_mode}, 32'h1);
    rd(OFS_XBASE, 32'hFFF0_0000);
    rd(OFS_CORE_ST, 32'h3);
    rd(OFS_SAVED, 32'h0005);
    rd(8'h3C, 32'hFC);
    wr(OFS_CORE_ST, 32'h2);
    rd(OFS_CORE_ST, 32'h1);
    wr(OFS_CMD, 32'h2);
    @(posedge sys_clk);
    chk({31'h0, sup_mode}, 32'h0);
    rd(8'h3C, 32'h100);
    wr(OFS_CMD, 32'h2);
    @(posedge sys_clk);
    chk({31'h0, sup_mode}, 32'h1);
    rd(OFS_CORE_ST, 32'h3);
    wr(OFS_CORE_ST, 32'h2);
    wr(OFS_CMD, 32'h2);
    wr(OFS_CCTL, 32'h0);
    chk({31'h0, icache_en}, 32'h1);
    rd(OFS_CORE_ST, 32'h3);
    wr(OFS_CMD, 32'h2);
    wr(OFS_PSW, 32'h2000);
    rd(OFS_PSW, 32'h2005);
  endtask : t_priv
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    req = '0;
    req.byteenable = 4'hF;
    fetch_addr = 32'h0;
    bad_count = 0;
    n_checks = 0;
    cycles = 0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_gen();
    t_ctl();
    t_alu();
    t_ea();
    t_move();
    t_priv();
    print_verdict();
  end
endmodule : cpu_programming_model_test
`default_nettype wire

// ===== verilog/cpm_core_regs.sv
// Purpose: Programmer-visible register set of the core, bus reachable
// Assumes: Avalon-MM master holds requests until waitrequest is low
// Notes: Every access is answered one cycle after it is presented
//
// Notes on behaviour
// - Eight data, seven address, one stack register
// - Any register indexes; address registers form bases
// - User mode reaches only the flags byte
// - Upper status byte is supervisor only
// - Vector base keeps upper 12 bits only
// - Cache control register enables instruction cache
// - Two region registers mark space noncacheable
// - Arithmetic is two's complement throughout
// - Operand sizes bit, byte, word, longword
// - Seven effective address mode families supported
// - Index value is scaled before adding
// - Instruction pointer is base for relative modes
// - Operations update flags for later tests
// - Move destinations restricted by source mode
// - Privilege bit set means supervisor mode
// - Exception entry stacks status, then sets privilege
// - Privilege bit changes allowed only in supervisor
//
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module cpm_core_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire cpm_pkg::cpm_avs_req_type avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [31:0] fetch_addr,
  output logic sup_mode,
  output logic icache_en,
  output logic fetch_cacheable,
  output logic [31:0] vector_base
);
  import cpm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (nw & m);
  endfunction : merge

  function automatic logic region_hit(input logic [31:0] ra,
                                      input logic [31:0] a);
    return ra[RA_EN_BIT] && ra[RA_NC_BIT] &&
      (((a[31:24] ^ ra[31:24]) & ~ra[23:16]) == 8'h00);
  endfunction : region_hit

  function automatic logic move_legal(input cpm_ea_mode_type src,
                                      input cpm_ea_mode_type dst);
    logic simple;
    logic alter;
    simple = dst <= EA_PREDEC;
    alter = !(dst inside {EA_PCDISP, EA_PCINDEX, EA_IMM}) && dst <= EA_IMM;
    case (src)
      EA_DREG, EA_AREG, EA_IND, EA_POSTINC, EA_PREDEC: return alter;
      EA_DISP, EA_PCDISP: return simple || dst == EA_DISP;
      EA_INDEX, EA_PCINDEX, EA_ABSW, EA_ABSL, EA_IMM: return simple;
      default: return 1'b0;
    endcase
  endfunction : move_legal

  function automatic cpm_alu_out_type alu_exec(input logic [31:0] a,
                                               input logic [31:0] b,
                                               input cpm_alu_op_type op,
                                               input cpm_size_type sz,
                                               input logic [4:0] cc);
    logic [4:0] sh;
    logic [31:0] as_;
    logic [31:0] bs_;
    logic [31:0] mk;
    logic [32:0] s;
    logic v;
    cpm_alu_out_type o;
    // Operands are left-aligned so carry and sign sit at fixed bits
    sh = (sz == SZ_BYTE) ? SH_BYTE : (sz == SZ_WORD) ? SH_WORD : 5'h00;
    as_ = a << sh;
    bs_ = b << sh;
    mk = ALL_ONES >> sh;
    v = 1'b0;
    case (op)
      ALU_ADD: begin
        s = {1'b0, as_} + {1'b0, bs_};
        v = (as_[31] == bs_[31]) && (s[31] != as_[31]);
      end
      ALU_SUB, ALU_CMP: begin
        s = {1'b0, as_} - {1'b0, bs_};
        v = (as_[31] != bs_[31]) && (s[31] != as_[31]);
      end
      ALU_NEG: begin
        s = 33'h0_0000_0000 - {1'b0, as_};
        v = as_[31] && s[31];
      end
      ALU_AND: s = {1'b0, as_ & bs_};
      ALU_OR: s = {1'b0, as_ | bs_};
      ALU_XOR: s = {1'b0, as_ ^ bs_};
      default: s = '0;
    endcase
    o.res = (op == ALU_CMP) ? a : ((a & ~mk) | ((s[31:0] >> sh) & mk));
    o.flags = cc;
    o.flags[CC_N] = s[31];
    o.flags[CC_Z] = s[31:0] == 32'h0000_0000;
    o.flags[CC_V] = v;
    o.flags[CC_C] = s[32];
    if (op inside {ALU_ADD, ALU_SUB, ALU_NEG}) begin
      o.flags[CC_X] = s[32];
    end
    if (sz == SZ_BIT) begin
      o.res = a;
      o.flags = cc;
      o.flags[CC_Z] = !a[b[4:0]];
    end
    return o;
  endfunction : alu_exec

  ////////////////////////////////////////////////////////////////////////
  // State and decode

  logic [31:0] gen_r [NUM_GEN];
  logic [31:0] ip_r;
  logic [15:0] status_r;
  logic [15:0] status_nxt;
  logic [15:0] saved_r;
  logic viol_r;
  logic [31:0] xbase_r;
  logic [31:0] cctl_r;
  logic [31:0] ra0_r;
  logic [31:0] ra1_r;
  logic [31:0] ea_ext_r;
  logic [31:0] ea_res_r;
  logic [31:0] alu_a_r;
  logic [31:0] alu_b_r;
  logic [31:0] alu_res_r;
  logic move_ok_r;
  logic [31:0] rd_val;
  logic [31:0] wr_m;
  logic sup_only;
  logic [7:0] ofs;
  logic [3:0] gidx;
  logic req;
  logic acc;
  logic blocked;
  logic viol_ev;
  logic ok_wr;
  logic exc_enter;
  logic exc_ret;
  logic ea_go;
  logic alu_go;
  cpm_ea_mode_type ea_mode;
  logic [3:0] ea_bidx;
  logic [31:0] ea_val;
  logic [31:0] ea_nb;
  logic ea_wb;
  cpm_alu_out_type alu_o;

  assign ofs = avs_req.address;
  assign gidx = ofs[5:2];
  assign req = avs_req.read || avs_req.write;
  assign acc = req && !avs_waitrequest;
  assign blocked = !status_r[PSW_S_BIT] && sup_only;
  assign viol_ev = acc && blocked;
  assign ok_wr = acc && avs_req.write && !blocked;
  assign wr_m = merge(rd_val, avs_req.writedata, avs_req.byteenable);
  assign exc_enter = viol_ev ||
    (ok_wr && ofs == OFS_CMD && avs_req.writedata[CMD_ENTER]);
  assign exc_ret = ok_wr && ofs == OFS_CMD && !exc_enter &&
    avs_req.writedata[CMD_RET];
  assign ea_go = ok_wr && ofs == OFS_EA_CTL;
  assign alu_go = ok_wr && ofs == OFS_ALU_CTL;
  assign ea_mode = cpm_ea_mode_type'(avs_req.writedata[EA_MODE_LSB +: 4]);
  // Data-direct picks a data register, all else an address register
  assign ea_bidx = {ea_mode != EA_DREG,
                    avs_req.writedata[EA_REG_LSB +: 3]};
  assign alu_o = alu_exec(alu_a_r, alu_b_r,
    cpm_alu_op_type'(avs_req.writedata[ALU_OP_LSB +: 3]),
    cpm_size_type'(avs_req.writedata[ALU_SIZE_LSB +: 2]),
    status_r[FLAG_W-1:0]);

  cpm_ea_unit u_ea (
    .mode(ea_mode),
    .base(gen_r[ea_bidx]),
    .index(gen_r[avs_req.writedata[EA_IDX_LSB +: 4]]),
    .scale(avs_req.writedata[EA_SCALE_LSB +: 2]),
    .size(cpm_size_type'(avs_req.writedata[EA_SIZE_LSB +: 2])),
    .ext(ea_ext_r),
    .ip(ip_r),
    .ea(ea_val),
    .new_base(ea_nb),
    .wb(ea_wb)
  );

  // Current value of the addressed register, and its privilege class
  always_comb begin
    rd_val = '0;
    sup_only = 1'b0;
    if (ofs < OFS_IP) begin
      rd_val = gen_r[gidx];
    end else begin
      case (ofs)
        OFS_IP: rd_val = ip_r;
        OFS_FLAGS: rd_val = 32'(status_r[7:0]);
        OFS_PSW: begin
          rd_val = 32'(status_r);
          sup_only = 1'b1;
        end
        OFS_XBASE: begin
          rd_val = xbase_r;
          sup_only = 1'b1;
        end
        OFS_CCTL: begin
          rd_val = cctl_r;
          sup_only = 1'b1;
        end
        OFS_RA0: begin
          rd_val = ra0_r;
          sup_only = 1'b1;
        end
        OFS_RA1: begin
          rd_val = ra1_r;
          sup_only = 1'b1;
        end
        OFS_SAVED: begin
          rd_val = 32'(saved_r);
          sup_only = 1'b1;
        end
        OFS_CMD: sup_only = avs_req.write &&
          avs_req.writedata[CMD_RET];
        OFS_EA_EXT: rd_val = ea_ext_r;
        OFS_EA_RES: rd_val = ea_res_r;
        OFS_ALU_A: rd_val = alu_a_r;
        OFS_ALU_B: rd_val = alu_b_r;
        OFS_ALU_RES: rd_val = alu_res_r;
        OFS_MOVE: rd_val = 32'(move_ok_r);
        OFS_CORE_ST: rd_val = 32'({viol_r, status_r[PSW_S_BIT]});
        default: rd_val = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake: answer one cycle after the request appears

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (req && avs_waitrequest) begin
        avs_readdata <= (avs_req.read && !blocked) ? rd_val : '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // General registers and instruction pointer

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_GEN; i++) begin
        gen_r[i] <= '0;
      end
      ip_r <= '0;
    end else if (ok_wr && ofs < OFS_IP) begin
      gen_r[gidx] <= wr_m;
    end else if (ok_wr && ofs == OFS_IP) begin
      ip_r <= wr_m;
    end else if (ea_go && ea_wb) begin
      gen_r[ea_bidx] <= ea_nb;
    end else if (exc_enter) begin
      gen_r[SP_IDX] <= gen_r[SP_IDX] - STACK_FRAME_BYTES;
    end else if (exc_ret) begin
      gen_r[SP_IDX] <= gen_r[SP_IDX] + STACK_FRAME_BYTES;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status word, stacked copy, violation flag

  always_comb begin
    status_nxt = status_r;
    if (exc_enter) begin
      status_nxt[PSW_S_BIT] = 1'b1;
    end else if (exc_ret) begin
      status_nxt = saved_r;
    end else if (ok_wr && ofs == OFS_PSW) begin
      status_nxt = wr_m[15:0];
    end else if (ok_wr && ofs == OFS_FLAGS) begin
      status_nxt[7:0] = wr_m[7:0];
    end else if (alu_go) begin
      status_nxt[FLAG_W-1:0] = alu_o.flags;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_r <= PSW_RESET;
      sup_mode <= 1'b1;
      saved_r <= '0;
    end else begin
      status_r <= status_nxt;
      sup_mode <= status_nxt[PSW_S_BIT];
      if (exc_enter) begin
        saved_r <= status_r;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      viol_r <= 1'b0;
    end else if (viol_ev) begin
      viol_r <= 1'b1;
    end else if (ok_wr && ofs == OFS_CORE_ST &&
                 avs_req.writedata[ST_VIOL]) begin
      viol_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Supervisor control registers and cacheability

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      xbase_r <= '0;
      vector_base <= '0;
      cctl_r <= '0;
      icache_en <= 1'b0;
      ra0_r <= '0;
      ra1_r <= '0;
      fetch_cacheable <= 1'b0;
    end else begin
      if (ok_wr && ofs == OFS_XBASE) begin
        xbase_r <= wr_m & XBASE_MASK;
        vector_base <= wr_m & XBASE_MASK;
      end
      if (ok_wr && ofs == OFS_CCTL) begin
        cctl_r <= wr_m;
        icache_en <= wr_m[CCTL_EN_BIT];
      end
      if (ok_wr && ofs == OFS_RA0) begin
        ra0_r <= wr_m;
      end
      if (ok_wr && ofs == OFS_RA1) begin
        ra1_r <= wr_m;
      end
      fetch_cacheable <= cctl_r[CCTL_EN_BIT] &&
        !region_hit(ra0_r, fetch_addr) &&
        !region_hit(ra1_r, fetch_addr);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address, arithmetic and move-check engines

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ea_ext_r <= '0;
      ea_res_r <= '0;
      alu_a_r <= '0;
      alu_b_r <= '0;
      alu_res_r <= '0;
      move_ok_r <= 1'b0;
    end else begin
      if (ok_wr && ofs == OFS_EA_EXT) begin
        ea_ext_r <= wr_m;
      end
      if (ea_go) begin
        ea_res_r <= ea_val;
      end
      if (ok_wr && ofs == OFS_ALU_A) begin
        alu_a_r <= wr_m;
      end
      if (ok_wr && ofs == OFS_ALU_B) begin
        alu_b_r <= wr_m;
      end
      if (alu_go) begin
        alu_res_r <= alu_o.res;
      end
      if (ok_wr && ofs == OFS_MOVE) begin
        move_ok_r <= move_legal(
          cpm_ea_mode_type'(avs_req.writedata[MV_SRC_LSB +: 4]),
          cpm_ea_mode_type'(avs_req.writedata[MV_DST_LSB +: 4]));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_xbase_align;
    ok_wr && ofs == OFS_XBASE |=>
      vector_base == ($past(wr_m) & XBASE_MASK) && xbase_r == vector_base;
  endproperty
  a_xbase_align: assert property (p_xbase_align)
    else $error("vector base not aligned to written upper bits");

  property p_flags_only;
    acc && avs_req.write && !status_r[PSW_S_BIT] && ofs == OFS_FLAGS
      |=> $stable(status_r[15:8]) && !sup_mode;
  endproperty
  a_flags_only: assert property (p_flags_only)
    else $error("user flags write touched upper status byte");

  property p_priv_block;
    viol_ev && ofs == OFS_CCTL |=> $stable(cctl_r) && viol_r && sup_mode;
  endproperty
  a_priv_block: assert property (p_priv_block)
    else $error("user write to cache control not blocked");

  property p_user_psw;
    acc && avs_req.write && !status_r[PSW_S_BIT] && ofs == OFS_PSW
      |=> sup_mode && status_r[7:0] == $past(status_r[7:0]) && viol_r;
  endproperty
  a_user_psw: assert property (p_user_psw)
    else $error("user status write not turned into a violation");

  property p_exc_entry;
    exc_enter |=> sup_mode && saved_r == $past(status_r) &&
      gen_r[SP_IDX] == $past(gen_r[SP_IDX]) - STACK_FRAME_BYTES;
  endproperty
  a_exc_entry: assert property (p_exc_entry)
    else $error("exception entry did not stack status and set privilege");

  property p_sbit;
    sup_mode == status_r[PSW_S_BIT];
  endproperty
  a_sbit: assert property (p_sbit)
    else $error("mode output differs from privilege bit");

  property p_cache;
    ok_wr && ofs == OFS_CCTL |=> icache_en == $past(wr_m[CCTL_EN_BIT])
      ##1 (icache_en || !fetch_cacheable);
  endproperty
  a_cache: assert property (p_cache)
    else $error("cache enable not following control register");

  property p_region;
    region_hit(ra0_r, fetch_addr) || region_hit(ra1_r, fetch_addr)
      |=> !fetch_cacheable;
  endproperty
  a_region: assert property (p_region)
    else $error("noncacheable region reported cacheable");

  property p_alu_add;
    alu_go && avs_req.writedata[ALU_OP_LSB +: 3] == ALU_ADD &&
      avs_req.writedata[ALU_SIZE_LSB +: 2] == SZ_LONG
      |=> alu_res_r == $past(alu_a_r + alu_b_r) &&
        status_r[CC_Z] == (alu_res_r == 32'h0000_0000);
  endproperty
  a_alu_add: assert property (p_alu_add)
    else $error("longword add result or zero flag wrong");

  property p_move;
    ok_wr && ofs == OFS_MOVE &&
      avs_req.writedata[MV_SRC_LSB +: 4] == EA_IMM &&
      avs_req.writedata[MV_DST_LSB +: 4] == EA_DISP |=> !move_ok_r;
  endproperty
  a_move: assert property (p_move)
    else $error("immediate source accepted displacement destination");

  c_exc: cover property (exc_enter ##1 exc_ret);
  c_viol: cover property (viol_ev);
  c_alu_zero: cover property (alu_go ##1 status_r[CC_Z]);
  c_postinc: cover property (ea_go && ea_wb);

endmodule : cpm_core_regs
`default_nettype wire

// ===== verilog/cpm_ea_unit.sv
// Purpose: Effective-address arithmetic for one operand
// Assumes: Base, index and instruction pointer come from the register set
// Notes: Purely combinational; caller commits write-back of the base
`timescale 1ns/1ps
`default_nettype none
module cpm_ea_unit (
  input wire cpm_pkg::cpm_ea_mode_type mode,
  input wire logic [31:0] base,
  input wire logic [31:0] index,
  input wire logic [1:0] scale,
  input wire cpm_pkg::cpm_size_type size,
  input wire logic [31:0] ext,
  input wire logic [31:0] ip,
  output logic [31:0] ea,
  output logic [31:0] new_base,
  output logic wb
);
  import cpm_pkg::*;

  logic [31:0] step;
  logic [31:0] d16;
  logic [31:0] d8;
  logic [31:0] sidx;

  always_comb begin
    step = size_bytes(size);
    d16 = 32'(signed'(ext[15:0]));
    d8 = 32'(signed'(ext[7:0]));
    sidx = index << scale;
    ea = base;
    new_base = base;
    wb = 1'b0;
    case (mode)
      EA_DREG, EA_AREG, EA_IND: ea = base;
      EA_POSTINC: begin
        new_base = base + step;
        wb = 1'b1;
      end
      EA_PREDEC: begin
        ea = base - step;
        new_base = base - step;
        wb = 1'b1;
      end
      EA_DISP: ea = base + d16;
      EA_INDEX: ea = base + d8 + sidx;
      EA_PCDISP: ea = ip + d16;
      EA_PCINDEX: ea = ip + d8 + sidx;
      EA_ABSW: ea = d16;
      EA_ABSL, EA_IMM: ea = ext;
      default: ea = '0;
    endcase
  end

endmodule : cpm_ea_unit
`default_nettype wire

// ===== verilog/cpm_pkg.sv
// Purpose: Shared types, offsets and fields of the core register model
// Assumes: 32-bit Avalon-MM slave, byte addresses, one word per register
// Notes: Register offsets are byte addresses, all multiples of four
`default_nettype none
package cpm_pkg;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } cpm_avs_req_type;

  typedef struct packed {
    logic [31:0] res;
    logic [4:0] flags;
  } cpm_alu_out_type;

  typedef enum logic [3:0] {
    EA_DREG = 4'h0, EA_AREG = 4'h1, EA_IND = 4'h2, EA_POSTINC = 4'h3,
    EA_PREDEC = 4'h4, EA_DISP = 4'h5, EA_INDEX = 4'h6, EA_PCDISP = 4'h7,
    EA_PCINDEX = 4'h8, EA_ABSW = 4'h9, EA_ABSL = 4'hA, EA_IMM = 4'hB
  } cpm_ea_mode_type;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2, SZ_BIT = 2'h3
  } cpm_size_type;

  typedef enum logic [2:0] {
    ALU_ADD = 3'h0, ALU_SUB = 3'h1, ALU_AND = 3'h2, ALU_OR = 3'h3,
    ALU_XOR = 3'h4, ALU_CMP = 3'h5, ALU_NEG = 3'h6
  } cpm_alu_op_type;

  // Register map
  localparam logic [7:0] OFS_IP = 8'h40;
  localparam logic [7:0] OFS_FLAGS = 8'h44;
  localparam logic [7:0] OFS_PSW = 8'h48;
  localparam logic [7:0] OFS_XBASE = 8'h4C;
  localparam logic [7:0] OFS_CCTL = 8'h50;
  localparam logic [7:0] OFS_RA0 = 8'h54;
  localparam logic [7:0] OFS_RA1 = 8'h58;
  localparam logic [7:0] OFS_EA_CTL = 8'h5C;
  localparam logic [7:0] OFS_EA_EXT = 8'h60;
  localparam logic [7:0] OFS_EA_RES = 8'h64;
  localparam logic [7:0] OFS_ALU_A = 8'h68;
  localparam logic [7:0] OFS_ALU_B = 8'h6C;
  localparam logic [7:0] OFS_ALU_CTL = 8'h70;
  localparam logic [7:0] OFS_ALU_RES = 8'h74;
  localparam logic [7:0] OFS_MOVE = 8'h78;
  localparam logic [7:0] OFS_CMD = 8'h7C;
  localparam logic [7:0] OFS_CORE_ST = 8'h80;
  localparam logic [7:0] OFS_SAVED = 8'h84;

  localparam int NUM_GEN = 16;
  localparam logic [3:0] SP_IDX = 4'hF;
  localparam logic [31:0] STACK_FRAME_BYTES = 32'h0000_0004;

  // Status word and flags
  localparam int PSW_S_BIT = 13;
  localparam logic [15:0] PSW_RESET = 16'h2000;
  localparam int CC_C = 0;
  localparam int CC_V = 1;
  localparam int CC_Z = 2;
  localparam int CC_N = 3;
  localparam int CC_X = 4;
  localparam int FLAG_W = 5;

  localparam logic [31:0] XBASE_MASK = 32'hFFF0_0000;
  localparam int CCTL_EN_BIT = 31;
  localparam int RA_EN_BIT = 15;
  localparam int RA_NC_BIT = 6;

  // Command fields
  localparam int EA_MODE_LSB = 0;
  localparam int EA_REG_LSB = 4;
  localparam int EA_IDX_LSB = 8;
  localparam int EA_SCALE_LSB = 12;
  localparam int EA_SIZE_LSB = 16;
  localparam int ALU_OP_LSB = 0;
  localparam int ALU_SIZE_LSB = 4;
  localparam int MV_SRC_LSB = 0;
  localparam int MV_DST_LSB = 4;
  localparam int CMD_ENTER = 0;
  localparam int CMD_RET = 1;
  localparam int ST_SUP = 0;
  localparam int ST_VIOL = 1;

  localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;
  localparam logic [4:0] SH_BYTE = 5'h18;
  localparam logic [4:0] SH_WORD = 5'h10;

  function automatic logic [31:0] size_bytes(input cpm_size_type sz);
    case (sz)
      SZ_WORD: return 32'h0000_0002;
      SZ_LONG: return 32'h0000_0004;
      default: return 32'h0000_0001;
    endcase
  endfunction : size_bytes

endpackage : cpm_pkg
`default_nettype wire
